// >>> design/gpc_pkg.sv
// package: register map, field layout, reset values and types of the gain and pulse-output config block
`default_nettype none

package gpc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int unsigned GPC_ADDR_W  = 16;
    localparam int unsigned GPC_DATA_W  = 16;
    localparam int unsigned GPC_PHASES  = 3;
    localparam int unsigned GPC_PWR_W   = 24;   // per-phase power word
    localparam int unsigned GPC_SMP_W   = 24;   // adc sample word
    localparam int unsigned GPC_SHIFT_W = 3;    // gain as a left shift, 0..4
    localparam int unsigned GPC_SUM_W   = GPC_PWR_W + 2;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [15:0] GPC_OFS_COMP = 16'he60e;  // compensation_mode_reg
    localparam logic [15:0] GPC_OFS_GAIN = 16'he60f;  // channel_gain_select
    localparam logic [15:0] GPC_OFS_MODE = 16'he610;  // pulse_output_mode

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned GPC_CUR_GAIN_LSB  = 0;
    localparam int unsigned GPC_VOLT_GAIN_LSB = 6;
    localparam int unsigned GPC_SRC_LSB       = 0;   // pulse n source at SRC_LSB + 3n
    localparam int unsigned GPC_PIN_OFF_LSB   = 9;   // pulse n pin off at 9 + n
    localparam int unsigned GPC_LATCH_LSB     = 12;  // pulse n latch at 12 + n
    localparam int unsigned GPC_INCL_LSB      = 0;   // pulse n phase incl at 3n
    localparam int unsigned GPC_FIELD_W       = 3;

    ////////////////////////////////////////////////////////////////////////
    // reset values and writable-bit masks
    localparam logic [15:0] GPC_GAIN_RST  = 16'h0000;
    localparam logic [15:0] GPC_MODE_RST  = 16'h0e88;
    localparam logic [15:0] GPC_COMP_RST  = 16'h01ff;
    localparam logic [15:0] GPC_GAIN_MASK = 16'h01c7;
    localparam logic [15:0] GPC_MODE_MASK = 16'h7fff;
    localparam logic [15:0] GPC_COMP_MASK = 16'h3fff;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        GPC_SRC_ACTIVE   = 3'b000,
        GPC_SRC_REACTIVE = 3'b001,
        GPC_SRC_APPARENT = 3'b010
    } gpc_src_e;

    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [GPC_ADDR_W-1:0]  addr;
        logic [GPC_DATA_W-1:0]  wdata;
    } gpc_host_req_s;

    typedef struct packed {
        logic [GPC_PHASES-1:0][GPC_PWR_W-1:0] active;
        logic [GPC_PHASES-1:0][GPC_PWR_W-1:0] reactive;
        logic [GPC_PHASES-1:0][GPC_PWR_W-1:0] apparent;
    } gpc_phase_pwr_s;

    // unassigned source codes act as active power
    function automatic gpc_src_e gpc_src_decode(input logic [2:0] code);
        case (code)
            3'b001:  gpc_src_decode = GPC_SRC_REACTIVE;
            3'b010:  gpc_src_decode = GPC_SRC_APPARENT;
            default: gpc_src_decode = GPC_SRC_ACTIVE;
        endcase
    endfunction

    // gain code to shift; unassigned codes give unity gain
    function automatic logic [GPC_SHIFT_W-1:0] gpc_gain_shift(input logic [2:0] code);
        case (code)
            3'b001:  gpc_gain_shift = 3'h1;
            3'b010:  gpc_gain_shift = 3'h2;
            3'b011:  gpc_gain_shift = 3'h3;
            3'b100:  gpc_gain_shift = 3'h4;
            default: gpc_gain_shift = 3'h0;
        endcase
    endfunction

endpackage

`default_nettype wire

// >>> design/gpc_pulse_chan.sv
// one pulse-output channel: source select, phase sum, pin gate and energy latch strobe
`default_nettype none

module gpc_pulse_chan
    import gpc_pkg::*;
(
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         srst,
    // configuration
    input  wire logic [2:0]                   source_sel,
    input  wire logic [2:0]                   phase_incl,
    input  wire logic                         pin_off,
    input  wire logic                         latch_en,
    // datapath
    input  wire gpc_pkg::gpc_phase_pwr_s      phase_pwr,
    input  wire logic                         dfc_pulse,
    output logic signed [GPC_SUM_W-1:0]       power_sum,
    output logic                              pulse_pin,
    output logic                              energy_latch
);

    import gpc_pkg::*;

    gpc_src_e                        src;
    logic [GPC_PHASES-1:0][GPC_PWR_W-1:0] picked;
    logic signed [GPC_SUM_W-1:0]     next_sum;

    ////////////////////////////////////////////////////////////////////////
    // pick the quantity, then add only the phases included for this output
    always_comb begin
        src = gpc_src_decode(source_sel);
        case (src)
            GPC_SRC_REACTIVE: picked = phase_pwr.reactive;
            GPC_SRC_APPARENT: picked = phase_pwr.apparent;
            default:          picked = phase_pwr.active;
        endcase
        next_sum = '0;
        for (int p = 0; p < GPC_PHASES; p++) begin
            if (phase_incl[p]) begin
                next_sum = next_sum + GPC_SUM_W'($signed(picked[p]));
            end
        end
    end

    // sum feeds the converter regardless of the pin gate
    always_ff @(posedge clock) begin
        if (srst) begin
            power_sum <= '0;
        end else begin
            power_sum <= next_sum;
        end
    end

    // pin gate only; converter pulses are still counted upstream
    always_ff @(posedge clock) begin
        if (srst) begin
            pulse_pin <= 1'b0;
        end else begin
            pulse_pin <= dfc_pulse & ~pin_off;
        end
    end

    // latch strobe follows converter pulses even with the pin gated off
    always_ff @(posedge clock) begin
        if (srst) begin
            energy_latch <= 1'b0;
        end else begin
            energy_latch <= dfc_pulse & latch_en;
        end
    end

endmodule

`default_nettype wire

// >>> design/gpc_config_top.sv
// gain and pulse-output configuration registers with the logic they steer
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module gpc_config_top
    import gpc_pkg::*;
#(
    parameter int unsigned SMP_W = GPC_SMP_W
)
(
    // clock and reset
    input  wire logic                              clock,
    input  wire logic                              srst,
    // host register port
    input  wire gpc_pkg::gpc_host_req_s            host_req,
    output logic [GPC_DATA_W-1:0]                  host_rdata,
    output logic                                   host_rvalid,
    // adc samples in and scaled samples out
    input  wire logic [GPC_PHASES-1:0][SMP_W-1:0]  current_smp,
    input  wire logic [GPC_PHASES-1:0][SMP_W-1:0]  voltage_smp,
    output logic [GPC_PHASES-1:0][SMP_W+3:0]       current_scaled,
    output logic [GPC_PHASES-1:0][SMP_W+3:0]       voltage_scaled,
    // decoded gain settings
    output logic [GPC_SHIFT_W-1:0]                 current_gain_shift,
    output logic [GPC_SHIFT_W-1:0]                 voltage_gain_shift,
    // per-phase powers in, summed powers out to the converters
    input  wire gpc_pkg::gpc_phase_pwr_s           phase_pwr,
    output logic signed [GPC_SUM_W-1:0]            pulse1_power,
    output logic signed [GPC_SUM_W-1:0]            pulse2_power,
    output logic signed [GPC_SUM_W-1:0]            pulse3_power,
    // raw converter pulses in, gated pins out
    input  wire logic                              dfc_pulse_1,
    input  wire logic                              dfc_pulse_2,
    input  wire logic                              dfc_pulse_3,
    output logic                                   pulse_out_1,
    output logic                                   pulse_out_2,
    output logic                                   pulse_out_3,
    // energy latch strobes
    output logic                                   pulse1_latch_strobe,
    output logic                                   pulse2_latch_strobe,
    output logic                                   pulse3_latch_strobe
);

    import gpc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [GPC_DATA_W-1:0] channel_gain_select;
    logic [GPC_DATA_W-1:0] pulse_output_mode;
    logic [GPC_DATA_W-1:0] compensation_mode_reg;

    // named fields
    logic [2:0] current_gain_sel;
    logic [2:0] voltage_gain_sel;
    logic [2:0] pulse1_source_sel;
    logic [2:0] pulse2_source_sel;
    logic [2:0] pulse3_source_sel;
    logic       pulse1_pin_off;
    logic       pulse2_pin_off;
    logic       pulse3_pin_off;
    logic       pulse1_energy_latch;
    logic       pulse2_energy_latch;
    logic       pulse3_energy_latch;
    logic [2:0] pulse1_phase_incl;
    logic [2:0] pulse2_phase_incl;
    logic [2:0] pulse3_phase_incl;

    // address decode
    logic hit_gain;
    logic hit_mode;
    logic hit_comp;

    // read path
    logic [GPC_DATA_W-1:0] next_rdata;

    // gain shift, registered together with the samples it scales
    logic [GPC_SHIFT_W-1:0] next_cur_shift;
    logic [GPC_SHIFT_W-1:0] next_volt_shift;

    ////////////////////////////////////////////////////////////////////////
    // address decode: an offset outside the three registers is unmapped
    assign hit_gain = (host_req.addr == GPC_OFS_GAIN);
    assign hit_mode = (host_req.addr == GPC_OFS_MODE);
    assign hit_comp = (host_req.addr == GPC_OFS_COMP);

    ////////////////////////////////////////////////////////////////////////
    // gain register; reserved bits are masked off at write so they never
    // hold anything but zero and cannot leak into the gain decode
    always_ff @(posedge clock) begin
        if (srst) begin
            channel_gain_select <= GPC_GAIN_RST;
        end else if (host_req.wr && hit_gain) begin
            channel_gain_select <= host_req.wdata & GPC_GAIN_MASK;
        end
    end

    // pulse-output mode register; bit 15 is dropped at write
    always_ff @(posedge clock) begin
        if (srst) begin
            pulse_output_mode <= GPC_MODE_RST;
        end else if (host_req.wr && hit_mode) begin
            pulse_output_mode <= host_req.wdata & GPC_MODE_MASK;
        end
    end

    // compensation-mode register; only the phase include fields steer
    // logic here, the remaining fields are kept for readback
    always_ff @(posedge clock) begin
        if (srst) begin
            compensation_mode_reg <= GPC_COMP_RST;
        end else if (host_req.wr && hit_comp) begin
            compensation_mode_reg <= host_req.wdata & GPC_COMP_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field extraction
    assign current_gain_sel    = channel_gain_select[GPC_CUR_GAIN_LSB +: GPC_FIELD_W];
    assign voltage_gain_sel    = channel_gain_select[GPC_VOLT_GAIN_LSB +: GPC_FIELD_W];
    assign pulse1_source_sel   = pulse_output_mode[GPC_SRC_LSB +: GPC_FIELD_W];
    assign pulse2_source_sel   = pulse_output_mode[GPC_SRC_LSB + GPC_FIELD_W +: GPC_FIELD_W];
    assign pulse3_source_sel   = pulse_output_mode[GPC_SRC_LSB + 2*GPC_FIELD_W +: GPC_FIELD_W];
    assign pulse1_pin_off      = pulse_output_mode[GPC_PIN_OFF_LSB];
    assign pulse2_pin_off      = pulse_output_mode[GPC_PIN_OFF_LSB + 1];
    assign pulse3_pin_off      = pulse_output_mode[GPC_PIN_OFF_LSB + 2];
    assign pulse1_energy_latch = pulse_output_mode[GPC_LATCH_LSB];
    assign pulse2_energy_latch = pulse_output_mode[GPC_LATCH_LSB + 1];
    assign pulse3_energy_latch = pulse_output_mode[GPC_LATCH_LSB + 2];
    assign pulse1_phase_incl   = compensation_mode_reg[GPC_INCL_LSB +: GPC_FIELD_W];
    assign pulse2_phase_incl   = compensation_mode_reg[GPC_INCL_LSB + GPC_FIELD_W +: GPC_FIELD_W];
    assign pulse3_phase_incl   = compensation_mode_reg[GPC_INCL_LSB + 2*GPC_FIELD_W +: GPC_FIELD_W];

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets read zero, stored values are already
    // masked so reserved positions come back as zero
    always_comb begin
        next_rdata = '0;
        if (hit_gain) begin
            next_rdata = channel_gain_select;
        end else if (hit_mode) begin
            next_rdata = pulse_output_mode;
        end else if (hit_comp) begin
            next_rdata = compensation_mode_reg;
        end
    end

    // read data is held until the next read so a slow host can sample it
    always_ff @(posedge clock) begin
        if (srst) begin
            host_rdata <= '0;
        end else if (host_req.rd) begin
            host_rdata <= next_rdata;
        end
    end

    // one-cycle marker that host_rdata holds a fresh answer
    always_ff @(posedge clock) begin
        if (srst) begin
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_req.rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gain decode; the function sends 101..111 to a zero shift
    assign next_cur_shift  = gpc_gain_shift(current_gain_sel);
    assign next_volt_shift = gpc_gain_shift(voltage_gain_sel);

    // decoded gain, registered so it changes in step with scaled samples
    always_ff @(posedge clock) begin
        if (srst) begin
            current_gain_shift <= '0;
            voltage_gain_shift <= '0;
        end else begin
            current_gain_shift <= next_cur_shift;
            voltage_gain_shift <= next_volt_shift;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // digital gain: the output is four bits wider than the sample, so a
    // gain of 16 never overflows; the cost is wider downstream words
    always_ff @(posedge clock) begin
        if (srst) begin
            current_scaled <= '0;
            voltage_scaled <= '0;
        end else begin
            for (int p = 0; p < GPC_PHASES; p++) begin
                current_scaled[p] <= (SMP_W+4)'($signed(current_smp[p])) <<< next_cur_shift;
                voltage_scaled[p] <= (SMP_W+4)'($signed(voltage_smp[p])) <<< next_volt_shift;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse output 1
    gpc_pulse_chan u_chan1 (
        .clock        (clock),
        .srst         (srst),
        .source_sel   (pulse1_source_sel),
        .phase_incl   (pulse1_phase_incl),
        .pin_off      (pulse1_pin_off),
        .latch_en     (pulse1_energy_latch),
        .phase_pwr    (phase_pwr),
        .dfc_pulse    (dfc_pulse_1),
        .power_sum    (pulse1_power),
        .pulse_pin    (pulse_out_1),
        .energy_latch (pulse1_latch_strobe)
    );

    // pulse output 2
    gpc_pulse_chan u_chan2 (
        .clock        (clock),
        .srst         (srst),
        .source_sel   (pulse2_source_sel),
        .phase_incl   (pulse2_phase_incl),
        .pin_off      (pulse2_pin_off),
        .latch_en     (pulse2_energy_latch),
        .phase_pwr    (phase_pwr),
        .dfc_pulse    (dfc_pulse_2),
        .power_sum    (pulse2_power),
        .pulse_pin    (pulse_out_2),
        .energy_latch (pulse2_latch_strobe)
    );

    // pulse output 3
    gpc_pulse_chan u_chan3 (
        .clock        (clock),
        .srst         (srst),
        .source_sel   (pulse3_source_sel),
        .phase_incl   (pulse3_phase_incl),
        .pin_off      (pulse3_pin_off),
        .latch_en     (pulse3_energy_latch),
        .phase_pwr    (phase_pwr),
        .dfc_pulse    (dfc_pulse_3),
        .power_sum    (pulse3_power),
        .pulse_pin    (pulse_out_3),
        .energy_latch (pulse3_latch_strobe)
    );

endmodule

`default_nettype wire

// >>> tb/gpc_config_props.sv
// checker: port-level properties of the gain and pulse-output config block
`default_nettype none

module gpc_config_props
    import gpc_pkg::*;
(
    // clock and reset
    input wire logic                         clock,
    input wire logic                         srst,
    // host register port
    input wire gpc_pkg::gpc_host_req_s       host_req,
    input wire logic [GPC_DATA_W-1:0]        host_rdata,
    input wire logic                         host_rvalid,
    // decoded gains
    input wire logic [GPC_SHIFT_W-1:0]       current_gain_shift,
    input wire logic [GPC_SHIFT_W-1:0]       voltage_gain_shift,
    // pulse path
    input wire logic                         dfc_pulse_1,
    input wire logic                         dfc_pulse_2,
    input wire logic                         dfc_pulse_3,
    input wire logic                         pulse_out_1,
    input wire logic                         pulse_out_2,
    input wire logic                         pulse_out_3,
    input wire logic                         pulse1_latch_strobe,
    input wire logic                         pulse2_latch_strobe,
    input wire logic                         pulse3_latch_strobe
);
    logic [15:0] mode_shadow;
    logic [15:0] gain_shadow;
    logic [2:0]  raw;
    logic [2:0]  pout;
    logic [2:0]  stb;

    // unassigned gain codes fall back to unity, i.e. no shift
    function automatic logic [2:0] shift_of(input logic [2:0] c);
        return (c > 3'h4) ? 3'h0 : c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // shadow copies of the two registers, so gating and read data can be predicted
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_shadow <= 16'h0e88;
            gain_shadow <= 16'h0000;
        end else if (host_req.wr) begin
            if (host_req.addr == 16'he610) mode_shadow <= host_req.wdata & 16'h7fff;
            if (host_req.addr == 16'he60f) gain_shadow <= host_req.wdata & 16'h01c7;
        end
    end

    // bundle the three outputs so one property covers all of them
    assign raw  = {dfc_pulse_3, dfc_pulse_2, dfc_pulse_1};
    assign pout = {pulse_out_3, pulse_out_2, pulse_out_1};
    assign stb  = {pulse3_latch_strobe, pulse2_latch_strobe, pulse1_latch_strobe};

    ////////////////////////////////////////////////////////////////////////////
    // the edge right after reset is skipped: $past still sees reset-time values
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    pin_gate_a: assert property (!$past(srst) |-> pout == $past(raw & ~mode_shadow[11:9]))
        else $error("pulse pin gating wrong");
    energy_latch_a: assert property (!$past(srst) |-> stb == $past(raw & mode_shadow[14:12]))
        else $error("latch strobe wrong");
    read_valid_a: assert property (!$past(srst) |-> host_rvalid == $past(host_req.rd))
        else $error("read valid timing wrong");
    mode_readback_a: assert property (host_rvalid && $past(host_req.addr) == 16'he610
        |-> host_rdata == $past(mode_shadow)) else $error("mode read data wrong");
    gain_readback_a: assert property (host_rvalid && $past(host_req.addr) == 16'he60f
        |-> host_rdata == $past(gain_shadow)) else $error("gain read data wrong");
    unmapped_zero_a: assert property (host_rvalid && !($past(host_req.addr) inside {16'he60e, 16'he60f,
        16'he610}) |-> host_rdata == 16'h0000) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!$past(srst) && !host_rvalid |-> $stable(host_rdata))
        else $error("read data changed without a read");
    cur_gain_a: assert property (!$past(srst) |-> current_gain_shift == shift_of($past(gain_shadow[2:0])))
        else $error("current gain decode wrong");
    volt_gain_a: assert property (!$past(srst) |-> voltage_gain_shift == shift_of($past(gain_shadow[8:6])))
        else $error("voltage gain decode wrong");

    pin_pulse_c: cover property (pulse_out_1 && pulse1_latch_strobe);
    latch_gated_c: cover property (pulse2_latch_strobe && !pulse_out_2);
    wr_rd_same_c: cover property (host_req.wr && host_req.rd);
endmodule

bind gpc_config_top gpc_config_props i_gpc_config_props (
    .clock(clock), .srst(srst), .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .current_gain_shift(current_gain_shift), .voltage_gain_shift(voltage_gain_shift),
    .dfc_pulse_1(dfc_pulse_1), .dfc_pulse_2(dfc_pulse_2), .dfc_pulse_3(dfc_pulse_3),
    .pulse_out_1(pulse_out_1), .pulse_out_2(pulse_out_2), .pulse_out_3(pulse_out_3),
    .pulse1_latch_strobe(pulse1_latch_strobe), .pulse2_latch_strobe(pulse2_latch_strobe),
    .pulse3_latch_strobe(pulse3_latch_strobe)
);

`default_nettype wire

// >>> tb/tb_top.sv
// testbench: register, gain and pulse-output checks of the config block
`default_nettype none

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import gpc_pkg::*;

    typedef struct packed {
        logic [15:0] mode; logic [15:0] comp;
        logic [25:0] s1; logic [25:0] s2; logic [25:0] s3;
        logic [2:0] raw; logic [2:0] pin; logic [2:0] stb;
    } gpc_row_s;

    logic                                  clock    = 1'b0;
    logic                                  srst     = 1'b1;
    gpc_host_req_s                         req      = '0;
    logic [2:0]                            dfc      = 3'b000;
    logic [GPC_PHASES-1:0][GPC_SMP_W-1:0]  cur_smp  = {3{24'hfffffd}};
    logic [GPC_PHASES-1:0][GPC_SMP_W-1:0]  volt_smp = {3{24'h000005}};
    // each phase and quantity has its own bit, so a sum names exactly what was picked
    gpc_phase_pwr_s pwr = {24'd4, 24'd2, 24'd1, 24'd64, 24'd32, 24'd16, 24'd1024, 24'd512, 24'd256};
    logic [15:0]                           rdata;
    logic                                  rvalid;
    logic [GPC_PHASES-1:0][GPC_SMP_W+3:0]  cur_sc;
    logic [GPC_PHASES-1:0][GPC_SMP_W+3:0]  volt_sc;
    logic [2:0]                            cur_sh;
    logic [2:0]                            volt_sh;
    logic signed [GPC_SUM_W-1:0]           p1;
    logic signed [GPC_SUM_W-1:0]           p2;
    logic signed [GPC_SUM_W-1:0]           p3;
    wire [2:0]                             pout;     // one bit per output, each driven by its own port
    wire [2:0]                             stb;
    logic [2:0]                            cc;
    logic [2:0]                            ec;
    logic [2:0]                            ev;
    int                                    fails    = 0;
    int                                    n_tests  = 0;
    // mode, compensation, expected sums 1..3, raw pulses, expected pins and strobes
    gpc_row_s rows [4] = '{
        '{16'h0e88, 16'h01ff, 26'd7, 26'd112, 26'd1792, 3'b111, 3'b000, 3'b000},
        '{16'h7163, 16'h0111, 26'd1, 26'd2, 26'd4, 3'b101, 3'b101, 3'b101},
        '{16'h227e, 16'h017b, 26'd3, 26'd7, 26'd80, 3'b111, 3'b110, 3'b010},
        '{16'hfe42, 16'h01ff, 26'd1792, 26'd7, 26'd112, 3'b011, 3'b000, 3'b011}};

    gpc_config_top i_gpc_config_top (
        .clock(clock), .srst(srst), .host_req(req), .host_rdata(rdata), .host_rvalid(rvalid),
        .current_smp(cur_smp), .voltage_smp(volt_smp), .current_scaled(cur_sc), .voltage_scaled(volt_sc),
        .current_gain_shift(cur_sh), .voltage_gain_shift(volt_sh), .phase_pwr(pwr),
        .pulse1_power(p1), .pulse2_power(p2), .pulse3_power(p3),
        .dfc_pulse_1(dfc[0]), .dfc_pulse_2(dfc[1]), .dfc_pulse_3(dfc[2]),
        .pulse_out_1(pout[0]), .pulse_out_2(pout[1]), .pulse_out_3(pout[2]),
        .pulse1_latch_strobe(stb[0]), .pulse2_latch_strobe(stb[1]), .pulse3_latch_strobe(stb[2]));

    ////////////////////////////////////////////////////////////////////////////
    // clock generator
    initial begin
        forever #25 clock = ~clock;
    end

    // one-cycle write strobe; the idle edge after it keeps strobes from merging
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock) req <= {1'b1, 1'b0, a, d};
        @(posedge clock) req <= '0;
    endtask

    // read strobe, then sample the answer mid-cycle once it has settled
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clock) req <= {1'b0, 1'b1, a, 16'h0000};
        @(posedge clock) req <= '0;
        @(negedge clock);
        `CHK(rvalid, 1'b1)
        `CHK(rdata, exp)
    endtask

    task automatic stop_test;
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        rd(GPC_OFS_GAIN, 16'h0000);
        rd(GPC_OFS_MODE, 16'h0e88);
        rd(GPC_OFS_COMP, 16'h01ff);
        wr(16'he611, 16'hffff);
        rd(16'he611, 16'h0000);
        // table rows: every source code appears in some field
        foreach (rows[i]) begin
            wr(GPC_OFS_MODE, rows[i].mode);
            wr(GPC_OFS_COMP, rows[i].comp);
            @(posedge clock) dfc <= rows[i].raw;
            @(posedge clock) dfc <= 3'b000;
            @(negedge clock);
            `CHK(pout, rows[i].pin)
            `CHK(stb, rows[i].stb)
            `CHK({p1, p2, p3}, {rows[i].s1, rows[i].s2, rows[i].s3})
            rd(GPC_OFS_MODE, rows[i].mode & 16'h7fff);
        end
        // all gain codes, reserved bits written as ones
        for (int c = 0; c < 8; c++) begin
            cc = 3'(c);
            wr(GPC_OFS_GAIN, {7'h7f, ~cc, 3'h7, cc});
            repeat (2) @(posedge clock);
            @(negedge clock);
            ec = (cc > 3'h4) ? 3'h0 : cc;
            ev = (~cc > 3'h4) ? 3'h0 : ~cc;
            `CHK(cur_sh, ec)
            `CHK(volt_sh, ev)
            `CHK({cur_sc, volt_sc}, {{3{28'hffffffd << ec}}, {3{28'h0000005 << ev}}})
            rd(GPC_OFS_GAIN, {7'h00, ~cc, 3'h0, cc});
        end
        // write and read in one cycle must return the value held before the write
        @(posedge clock) req <= {1'b1, 1'b1, GPC_OFS_MODE, 16'h0000};
        @(posedge clock) req <= '0;
        @(negedge clock);
        `CHK(rdata, rows[3].mode & 16'h7fff)
        rd(GPC_OFS_MODE, 16'h0000);
        // reset in mid-run restores the defaults
        @(posedge clock) srst <= 1'b1;
        @(posedge clock) srst <= 1'b0;
        rd(GPC_OFS_MODE, 16'h0e88);
        rd(GPC_OFS_GAIN, 16'h0000);
        stop_test;
    end

    // watchdog: the sequence needs about 116 cycles
    initial begin
        repeat (3000) @(posedge clock);
        fails++;
        stop_test;
    end
endmodule

`default_nettype wire
